// *** dmd_pkg.sv ***
package dmd_pkg;
  // ==========================================================================
  // widths
  localparam int unsigned PAGE_W   = 7;
  localparam int unsigned EXT_AW   = 23;
  localparam int unsigned VEC_W    = 5;
  // ==========================================================================
  // data space map
  localparam logic [15:0] PAGE_REG_ADDR = 16'h001E;
  localparam logic [15:0] RAM_LO        = 16'h0080;
  localparam logic [15:0] RAM_HI        = 16'h3FFF;
  localparam logic [15:0] RAM_BLK1_LO   = 16'h2000;
  // ==========================================================================
  // program space map
  localparam logic [15:0] ROM_LO        = 16'hC000;
  localparam logic [15:0] BOOT_LO       = 16'hF800;
  localparam logic [15:0] BOOT_HI       = 16'hFBFF;
  localparam logic [15:0] VEC_TBL_LO    = 16'hFF80;
  localparam logic [6:0]  ROM_PAGE      = 7'h00;
  // ==========================================================================
  // host port read window under full security
  localparam logic [15:0] HOST_RD_LO    = 16'h4000;
  localparam logic [15:0] HOST_RD_HI    = 16'h5FFF;
  // ==========================================================================
  // mode register fields and reset values
  localparam int unsigned VPTR_MSB      = 15;
  localparam int unsigned VPTR_LSB      = 7;
  localparam int unsigned BOOT_BIT      = 6;
  localparam int unsigned RAM_OVERLAY_ENABLE_BIT      = 5;
  localparam logic [8:0]  VPTR_RST      = 9'h1FF;
  localparam logic [6:0]  PAGE_RST      = 7'h00;
  localparam logic [15:0] SECURE_WORD   = 16'hFFFF;
endpackage : dmd_pkg

// *** dmd_decoder.sv ***
// Functional notes
// RQ1: in-bounds program address internal, else external
// RQ2: 128 pages of 64K on 23 lines
// RQ3: page register read/write at 001Eh
// RQ4: hardware reset clears page register
// RQ5: ROM mapped in program space only
// RQ6: boot select low starts at FF80h
// RQ7: ROM spans C000h to FFFFh
// RQ8: software leaves FF00h-FF7Fh unused
// RQ9: two independent 8K RAM blocks
// RQ10: RAM at 0080h-3FFFh, overlay into program
// RQ11: block zero low, block one high
// RQ12: secured ROM read from outside gives FFFFh
// RQ13: branching into ROM, RAM reads allowed
// RQ14: security kills emulation, keeps boundary scan
// RQ15: full security forces boot select zero
// RQ16: full security limits host reads 4000h-5FFFh
// RQ17: ROM-only security follows pin, host free
// RQ18: vectors at FF80h, movable by pointer
// RQ19: vector address is pointer plus slot
// RQ20: 9-bit pointer, reset ones, soft reset keeps
// RQ21: boot select zero maps ROM in
// RQ22: data page 0 never overlaid
// RQ23: extended address is page above address
`timescale 1ns/100ps
module dmd_decoder
  import dmd_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               sec_ram_rom,
  input  wire logic               sec_rom_only,
  input  wire logic               boot_rom_select_pin,
  input  wire logic [15:0]        prog_addr,
  input  wire logic               prog_data_read,
  input  wire logic               instr_from_rom,
  input  wire logic [15:0]        rom_rdata,
  input  wire logic [15:0]        data_a_addr,
  input  wire logic               data_a_rd,
  input  wire logic               data_a_wr,
  input  wire logic [15:0]        data_a_wdata,
  input  wire logic [15:0]        data_b_addr,
  input  wire logic               mode_wr,
  input  wire logic [15:0]        mode_wdata,
  input  wire logic               soft_reset,
  input  wire logic               host_req,
  input  wire logic               host_wr,
  input  wire logic [15:0]        host_addr,
  input  wire logic               vec_take,
  input  wire logic [VEC_W-1:0]   vec_num,
  output logic [EXT_AW-1:0]       prog_ext_addr_r,
  output logic                    prog_sel_rom_r,
  output logic                    prog_sel_ram_r,
  output logic                    prog_ram_blk_r,
  output logic                    prog_sel_ext_r,
  output logic [15:0]             prog_rdata_r,
  output logic                    data_a_ram0_r,
  output logic                    data_a_ram1_r,
  output logic                    data_a_ext_r,
  output logic                    data_a_page_reg_r,
  output logic                    data_b_ram0_r,
  output logic                    data_b_ram1_r,
  output logic                    data_b_ext_r,
  output logic [15:0]             page_reg_rdata_r,
  output logic [15:0]             mode_rdata_r,
  output logic                    host_grant_r,
  output logic                    host_deny_r,
  output logic [15:0]             vec_pc_r,
  output logic                    vec_pc_vld_r,
  output logic                    emu_enable_r,
  output logic                    bscan_enable_r
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [2:0]        pin_sync;
    logic              pin_val;
    logic [PAGE_W-1:0] page;
    logic [8:0]        vptr;
    logic              boot_sel;
    logic              overlay;
    logic [EXT_AW-1:0] pa;
    logic              p_rom;
    logic              p_ram;
    logic              p_blk;
    logic              p_ext;
    logic [15:0]       prd;
    logic              a_ram0;
    logic              a_ram1;
    logic              a_ext;
    logic              a_preg;
    logic              b_ram0;
    logic              b_ram1;
    logic              b_ext;
    logic [15:0]       preg_rd;
    logic              h_ok;
    logic              h_deny;
    logic [15:0]       vpc;
    logic              vvld;
    logic              emu;
    logic              bscan;
  } dmd_state_t;

  dmd_state_t st_r;
  dmd_state_t st_nxt;

  logic secure;
  logic p_ram_hit;
  logic p_rom_hit;
  logic a_ram_hit;
  logic b_ram_hit;
  logic a_preg_hit;
  logic host_rd_ok;

  always_comb begin
    secure     = sec_ram_rom | sec_rom_only;
    // RQ10 RQ22 overlay window
    p_ram_hit  = st_r.overlay & (prog_addr >= RAM_LO) & (prog_addr <= RAM_HI);
    // RQ7 RQ21 RQ5 ROM window
    p_rom_hit  = ~st_r.boot_sel & (st_r.page == ROM_PAGE) & (prog_addr >= ROM_LO);
    // RQ10 data window
    a_ram_hit  = (data_a_addr >= RAM_LO) & (data_a_addr <= RAM_HI);
    b_ram_hit  = (data_b_addr >= RAM_LO) & (data_b_addr <= RAM_HI);
    a_preg_hit = (data_a_addr == PAGE_REG_ADDR);
    // RQ16 RQ17 host read window
    host_rd_ok = ~sec_ram_rom | ((host_addr >= HOST_RD_LO) & (host_addr <= HOST_RD_HI));
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // pin crossing: change accepted once stages two and three agree
    st_nxt.pin_sync = {st_r.pin_sync[1:0], boot_rom_select_pin};
    if (st_r.pin_sync[1] == st_r.pin_sync[2]) begin
      st_nxt.pin_val = st_r.pin_sync[2];
    end

    // RQ23 RQ2 page over in-page address
    st_nxt.pa = {st_r.page, prog_addr};
    // RQ1 internal or external
    st_nxt.p_ram = p_ram_hit;
    st_nxt.p_rom = p_rom_hit & ~p_ram_hit;
    st_nxt.p_ext = ~p_ram_hit & ~p_rom_hit;
    // RQ9 block by address bit
    st_nxt.p_blk = prog_addr[13];

    // RQ12 RQ13 secured ROM data read
    if (secure & p_rom_hit & prog_data_read & ~instr_from_rom) begin
      st_nxt.prd = SECURE_WORD;
    end else begin
      st_nxt.prd = rom_rdata;
    end

    // RQ11 RQ9 data port block select
    st_nxt.a_ram0 = a_ram_hit & (data_a_addr < RAM_BLK1_LO);
    st_nxt.a_ram1 = a_ram_hit & (data_a_addr >= RAM_BLK1_LO);
    st_nxt.a_preg = a_preg_hit & (data_a_rd | data_a_wr);
    st_nxt.a_ext  = ~a_ram_hit & ~a_preg_hit;
    st_nxt.b_ram0 = b_ram_hit & (data_b_addr < RAM_BLK1_LO);
    st_nxt.b_ram1 = b_ram_hit & (data_b_addr >= RAM_BLK1_LO);
    st_nxt.b_ext  = ~b_ram_hit;

    // RQ3 page register access
    if (a_preg_hit & data_a_wr) begin
      st_nxt.page = data_a_wdata[PAGE_W-1:0];
    end
    st_nxt.preg_rd = {9'h000, st_r.page};

    // RQ20 RQ21 mode register write
    if (mode_wr) begin
      st_nxt.vptr     = mode_wdata[VPTR_MSB:VPTR_LSB];
      st_nxt.boot_sel = mode_wdata[BOOT_BIT];
      st_nxt.overlay  = mode_wdata[RAM_OVERLAY_ENABLE_BIT];
    end else if (soft_reset) begin
      st_nxt.overlay = 1'b0;
    end

    // RQ16 host access check
    st_nxt.h_ok   = host_req & (host_wr | host_rd_ok);
    st_nxt.h_deny = host_req & ~host_wr & ~host_rd_ok;

    // RQ19 RQ18 vector address
    st_nxt.vpc  = {st_r.vptr, vec_num, 2'b00};
    st_nxt.vvld = vec_take;

    // RQ14 emulation off when secure
    st_nxt.emu = ~secure;
    st_nxt.bscan = 1'b1;

    if (srst) begin
      // RQ4 page cleared
      st_nxt.page     = PAGE_RST;
      // RQ20 pointer to all ones
      st_nxt.vptr     = VPTR_RST;
      // RQ15 RQ17 RQ6 boot select at reset
      st_nxt.boot_sel = sec_ram_rom ? 1'b0 : st_nxt.pin_val;
      st_nxt.overlay  = 1'b0;
      st_nxt.pa       = '0;
      st_nxt.p_rom    = 1'b0;
      st_nxt.p_ram    = 1'b0;
      st_nxt.p_blk    = 1'b0;
      st_nxt.p_ext    = 1'b0;
      st_nxt.prd      = 16'h0000;
      st_nxt.a_ram0   = 1'b0;
      st_nxt.a_ram1   = 1'b0;
      st_nxt.a_ext    = 1'b0;
      st_nxt.a_preg   = 1'b0;
      st_nxt.b_ram0   = 1'b0;
      st_nxt.b_ram1   = 1'b0;
      st_nxt.b_ext    = 1'b0;
      st_nxt.preg_rd  = 16'h0000;
      st_nxt.h_ok     = 1'b0;
      st_nxt.h_deny   = 1'b0;
      st_nxt.vpc      = VEC_TBL_LO;
      st_nxt.vvld     = 1'b0;
      st_nxt.emu      = 1'b0;
      st_nxt.bscan    = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  // ==========================================================================
  // outputs
  assign prog_ext_addr_r   = st_r.pa;
  assign prog_sel_rom_r    = st_r.p_rom;
  assign prog_sel_ram_r    = st_r.p_ram;
  assign prog_ram_blk_r    = st_r.p_blk;
  assign prog_sel_ext_r    = st_r.p_ext;
  assign prog_rdata_r      = st_r.prd;
  assign data_a_ram0_r     = st_r.a_ram0;
  assign data_a_ram1_r     = st_r.a_ram1;
  assign data_a_ext_r      = st_r.a_ext;
  assign data_a_page_reg_r = st_r.a_preg;
  assign data_b_ram0_r     = st_r.b_ram0;
  assign data_b_ram1_r     = st_r.b_ram1;
  assign data_b_ext_r      = st_r.b_ext;
  assign page_reg_rdata_r  = st_r.preg_rd;
  assign mode_rdata_r      = {st_r.vptr, st_r.boot_sel, st_r.overlay, 5'b00000};
  assign host_grant_r      = st_r.h_ok;
  assign host_deny_r       = st_r.h_deny;
  assign vec_pc_r          = st_r.vpc;
  assign vec_pc_vld_r      = st_r.vvld;
  assign emu_enable_r      = st_r.emu;
  assign bscan_enable_r    = st_r.bscan;

  // ==========================================================================
  // assertions
  AST_EXT_ADDR: assert property (@(posedge core_clk) disable iff (srst) // RQ23
    !$past(srst) |-> prog_ext_addr_r == {$past(st_r.page), $past(prog_addr)})
    else $error("extended address not page over address");

  AST_ONE_TARGET: assert property (@(posedge core_clk) disable iff (srst) // RQ1
    !$past(srst) |-> $onehot({prog_sel_rom_r, prog_sel_ram_r, prog_sel_ext_r}))
    else $error("program access target not unique");

  AST_PAGE_RESET: assert property (@(posedge core_clk) // RQ4
    $past(srst) |-> mode_rdata_r[15:7] == 9'h1FF && st_r.page == 7'h00)
    else $error("reset values wrong");

  AST_PAGE_WRITE: assert property (@(posedge core_clk) disable iff (srst) // RQ3
    data_a_wr && data_a_addr == 16'h001E ##1 1'b1 |=>
      page_reg_rdata_r == {9'h000, $past(data_a_wdata[6:0], 2)})
    else $error("page register readback wrong");

  AST_ROM_WINDOW: assert property (@(posedge core_clk) disable iff (srst) // RQ7
    prog_sel_rom_r |-> prog_ext_addr_r[15:14] == 2'b11 && prog_ext_addr_r[22:16] == 7'h00)
    else $error("ROM selected outside its window");

  AST_DATA_BLOCKS: assert property (@(posedge core_clk) disable iff (srst) // RQ11
    !$past(srst) && $past(data_a_addr) >= 16'h2000 && $past(data_a_addr) <= 16'h3FFF
      |-> data_a_ram1_r && !data_a_ram0_r && !data_a_ext_r)
    else $error("block one not selected");

  AST_NO_PAGE0: assert property (@(posedge core_clk) disable iff (srst) // RQ22
    prog_sel_ram_r |-> prog_ext_addr_r[15:7] != 9'h000)
    else $error("data page 0 overlaid");

  AST_SECURE_READ: assert property (@(posedge core_clk) disable iff (srst) // RQ12
    (sec_ram_rom || sec_rom_only) && p_rom_hit && prog_data_read && !instr_from_rom
      |=> prog_rdata_r == 16'hFFFF)
    else $error("secured ROM contents leaked");

  AST_HOST_READ: assert property (@(posedge core_clk) disable iff (srst) // RQ16
    host_req && !host_wr && sec_ram_rom && host_addr < 16'h4000 |=> host_deny_r && !host_grant_r)
    else $error("host read outside window granted");

  AST_VECTOR: assert property (@(posedge core_clk) disable iff (srst) // RQ19
    vec_take |=> vec_pc_vld_r && vec_pc_r == {$past(mode_rdata_r[15:7]), $past(vec_num), 2'b00})
    else $error("vector address wrong");

  AST_SOFT_KEEP: assert property (@(posedge core_clk) disable iff (srst) // RQ20
    soft_reset && !mode_wr |=> $stable(mode_rdata_r[15:6]))
    else $error("soft reset changed pointer or boot select");

  AST_EMU: assert property (@(posedge core_clk) disable iff (srst) // RQ14
    !$past(srst) |-> emu_enable_r == !$past(sec_ram_rom || sec_rom_only) && bscan_enable_r)
    else $error("emulation enable wrong");

endmodule // dmd_decoder

// *** dmd_rom_model.sv ***
`timescale 1ns/100ps
module dmd_rom_model
  import dmd_pkg::*;
(
  input  wire logic [15:0] prog_addr,
  output logic      [15:0] rom_rdata
);
  // ==========================================================================
  // rom contents
  // program-space rom words
  always_comb begin
    if (prog_addr[15:7] == 9'h1FE) begin
      rom_rdata = 16'h0000;
    end else begin
      rom_rdata = prog_addr ^ 16'h5A5A;
    end
  end
endmodule // dmd_rom_model

// *** dsp_memory_map_decoder_tb_top.sv ***
`timescale 1ns/100ps
module dsp_memory_map_decoder_tb_top
  import dmd_pkg::*;
;
  typedef struct {logic [15:0] pa; logic [15:0] da; logic [5:0] ex; logic [2:0] bx;} dmd_row_t;
  logic core_clk, srst, s_rr, s_ro, pin, pdr, ifr, a_rd, a_wr, m_wr, s_rst, h_req, h_wr, v_tk;
  logic [15:0] pa, rom_d, da, a_wd, db, m_wd, h_ad, p_rd, pg_rd, m_rd, v_pc;
  logic [4:0]  v_n;
  logic [22:0] p_ext;
  logic p_rom, p_ram, p_blk, p_ext_s, a0, a1, ax, apg, b0, b1, bx, h_g, h_d, v_vld, emu, bsc;
  int fail_count = 0;
  int num_checks = 0;
  dmd_row_t rows [7] = '{
    '{16'hC000, 16'h0080, 6'b100100, 3'b100}, '{16'hFF80, 16'h1FFF, 6'b100100, 3'b100},
    '{16'hBFFF, 16'h2000, 6'b001010, 3'b010}, '{16'h0100, 16'h3FFF, 6'b001010, 3'b010},
    '{16'h1234, 16'h4000, 6'b001001, 3'b001}, '{16'hFFFF, 16'h007F, 6'b100001, 3'b001},
    '{16'h0000, 16'h001E, 6'b001000, 3'b001}};
  dmd_rom_model rom_u (.prog_addr(pa), .rom_rdata(rom_d));
  dmd_decoder dut_u (.core_clk(core_clk), .srst(srst), .sec_ram_rom(s_rr),
    .sec_rom_only(s_ro), .boot_rom_select_pin(pin), .prog_addr(pa), .prog_data_read(pdr),
    .instr_from_rom(ifr), .rom_rdata(rom_d), .data_a_addr(da), .data_a_rd(a_rd),
    .data_a_wr(a_wr), .data_a_wdata(a_wd), .data_b_addr(db), .mode_wr(m_wr),
    .mode_wdata(m_wd), .soft_reset(s_rst), .host_req(h_req), .host_wr(h_wr),
    .host_addr(h_ad), .vec_take(v_tk), .vec_num(v_n), .prog_ext_addr_r(p_ext),
    .prog_sel_rom_r(p_rom), .prog_sel_ram_r(p_ram), .prog_ram_blk_r(p_blk),
    .prog_sel_ext_r(p_ext_s), .prog_rdata_r(p_rd), .data_a_ram0_r(a0), .data_a_ram1_r(a1),
    .data_a_ext_r(ax), .data_a_page_reg_r(apg), .data_b_ram0_r(b0), .data_b_ram1_r(b1),
    .data_b_ext_r(bx), .page_reg_rdata_r(pg_rd), .mode_rdata_r(m_rd), .host_grant_r(h_g),
    .host_deny_r(h_d), .vec_pc_r(v_pc), .vec_pc_vld_r(v_vld), .emu_enable_r(emu),
    .bscan_enable_r(bsc));
  // ==========================================================================
  // clock and helpers
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [22:0] got, input logic [22:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step();
    @(negedge core_clk);
  endtask
  task rst(input logic rr, input logic ro, input logic p);
    s_rr = rr; s_ro = ro; pin = p; srst = 1'b1;
    repeat (10) step();
    srst = 1'b0;
  endtask
  task prog(input logic [15:0] a, input logic [2:0] ex);
    pa = a;
    step();
    chk({p_rom, p_ram, p_ext_s}, ex);
  endtask
  task host(input logic w, input logic [15:0] a, input logic [1:0] ex);
    h_req = 1'b1; h_wr = w; h_ad = a;
    step();
    h_req = 1'b0;
    chk({h_g, h_d}, ex);
    step();
  endtask
  task mode(input logic [15:0] d);
    m_wr = 1'b1; m_wd = d;
    step();
    m_wr = 1'b0;
    chk(m_rd, d);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    $display("[ERR] %0t run limit reached", $time);
    summarize();
  end
  // ==========================================================================
  // main sequence
  initial begin
    srst = 1'b1;
    {pdr, ifr, a_rd, a_wr, m_wr, s_rst, h_req, h_wr, v_tk} = '0;
    {pa, da, a_wd, db, m_wd, h_ad} = '0;
    v_n = '0;
    step();
    rst(1'b1, 1'b0, 1'b1);
    chk(m_rd, 16'hFF80);
    chk({pg_rd, emu, bsc}, 18'h00001);
    v_tk = 1'b1; v_n = 5'h1F;
    step();
    v_tk = 1'b0;
    chk({v_vld, v_pc}, 17'h1FFFC);
    $display("reset test done");
    a_rd = 1'b1;
    foreach (rows[i]) begin
      pa = rows[i].pa; da = rows[i].da; db = rows[i].da;
      step();
      chk({p_rom, p_ram, p_ext_s, a0, a1, ax}, rows[i].ex);
      chk({b0, b1, bx}, rows[i].bx);
      chk(p_ext, {7'h00, rows[i].pa});
    end
    a_rd = 1'b0;
    $display("decode table done");
    pa = 16'hC010; pdr = 1'b1;
    step();
    chk(p_rd, 16'hFFFF);
    ifr = 1'b1;
    step();
    chk(p_rd, 16'hC010 ^ 16'h5A5A);
    {pdr, ifr} = '0;
    da = 16'h001E; a_wr = 1'b1; a_wd = 16'hFFFF;
    step();
    a_wr = 1'b0;
    chk(apg, 1'b1);
    prog(16'hC000, 3'b001);
    chk(pg_rd, 16'h007F);
    chk(p_ext, {7'h7F, 16'hC000});
    a_wr = 1'b1; a_wd = 16'h0000;
    step();
    a_wr = 1'b0;
    $display("page and security done");
    mode(16'hFFA0);
    prog(16'h0100, 3'b010);
    prog(16'h0040, 3'b001);
    prog(16'h2100, 3'b010);
    chk(p_blk, 1'b1);
    mode(16'h02A0);
    v_tk = 1'b1; v_n = 5'h03;
    step();
    v_tk = 1'b0;
    chk({v_vld, v_pc}, 17'h1028C);
    s_rst = 1'b1;
    step();
    s_rst = 1'b0;
    chk(m_rd, 16'h0280);
    host(1'b0, 16'h4000, 2'b10);
    host(1'b0, 16'h5FFF, 2'b10);
    host(1'b0, 16'h6000, 2'b01);
    host(1'b0, 16'h3FFF, 2'b01);
    host(1'b1, 16'h0000, 2'b10);
    $display("mode vector host done");
    rst(1'b0, 1'b1, 1'b1);
    chk({m_rd, emu}, {16'hFFC0, 1'b0});
    prog(16'hC000, 3'b001);
    host(1'b0, 16'h6000, 2'b10);
    rst(1'b0, 1'b0, 1'b0);
    chk(m_rd, 16'hFF80);
    chk(v_pc, 16'hFF80);
    prog(16'hFF80, 3'b100);
    chk(emu, 1'b1);
    chk({p_rom, p_ram, p_ext_s}, 3'b100);
    $display("option resets done");
    summarize();
  end
endmodule // dsp_memory_map_decoder_tb_top
